/* swp_dev.sv */
/*
 swp_dev: flash device end; status read, status write, write enable latch,
 self-timed write cycle, software and hardware guard modes.
 Assumes the link clock stops outside frames and the select line stays high
 at least four system cycles between frames.
*/
`timescale 1ns/100ps
// Operation
// RULE_01: status read answered at any time, even busy
// RULE_02: host polls busy flag before new commands
// RULE_03: status byte repeats while select stays low; code stops reloading it once the bit count saturates
// RULE_04: status write needs prior write enable command
// RULE_05: write enable command sets the latch
// RULE_06: host sends select, command, one data byte
// RULE_07: status write keeps bits one and zero
// RULE_08: select must rise right after eighth data bit
// RULE_09: select rise starts the self-timed write cycle
// RULE_10: busy reads one during cycle, zero after
// RULE_11: cycle end clears the write enable latch
// RULE_12: status write updates the four guard bits
// RULE_13: status write sets or clears lock bit
// RULE_14: lock bit starts at zero
// RULE_15: lock zero: write allowed with latch set
// RULE_16: lock one, pin high: write allowed with latch
// RULE_17: lock one, pin low: every write refused
// RULE_18: hardware guard freezes guard bits, refuses writes
// RULE_19: hardware guard entered in either event order
// RULE_20: only pin going high leaves hardware guard
// RULE_21: guarded area refuses program, erase; bulk too
// RULE_22: pin tied high: only software guard applies
// RULE_23: busy one, controller ready zero until done
// RULE_24: busy at bit zero, latch at bit one
module swp_dev #(
   parameter int unsigned STATUS_WRITE_CMD_CYC = swp_pkg::CYC_STATUS_WRITE,
   parameter int unsigned PROG_CYC = swp_pkg::CYC_PROGRAM,
   parameter int unsigned CNT_W    = swp_pkg::LINK_CNT_W
) (
   // system side
   input  wire logic       clk_sys_i,
   input  wire logic       srst_i,
   // serial link, device end
   swp_link_if.dev         link,
   // status view
   output logic      [7:0] status_o,
   output logic            hw_guard_o,
   output logic            ctrl_ready_o,
   output logic            write_refused_o
);
   import swp_pkg::*;

   // link domain
   logic             in_frame_reg;
   logic [CNT_W-1:0] bit_cnt_reg;
   logic [31:0]      shin_reg;
   logic [7:0]       cmd_reg;
   logic [7:0]       data_reg;
   logic [23:0]      addr_reg;
   logic [6:0]       shout_reg;
   logic [7:0]       stat_l;
   logic [7:0]       byte_in;
   logic             rd_now;
   // system domain
   logic             sel_s;
   logic             wp_s;
   logic             sel_d_reg;
   logic             frame_end;
   logic             lock_reg;
   logic             tb_reg;
   logic [3:0]       bp_reg;
   logic             wel_reg;
   logic             busy_reg;
   logic             kind_status_write_cmd_reg;
   logic [CYC_W-1:0] cyc_reg;
   logic [7:0]       new_reg;
   logic             hpm_reg;
   logic             rdy_reg;
   logic             refused_reg;
   logic [7:0]       stat_view;
   logic             hpm_now;
   logic             is_write_latch_set_cmd;
   logic             is_status_write_cmd;
   logic             is_prog;
   logic             is_erase;
   logic             is_bulk;
   logic             go_status_write_cmd;
   logic             go_mod;
   logic             cyc_done;

   assign byte_in = {shin_reg[6:0], link.serial_in_line};

   // frame flag cleared by select high; data regs keep the last frame
   always_ff @(posedge link.sclk or posedge link.sel_n) begin
      if (link.sel_n) begin
         in_frame_reg <= 1'b0;
      end else begin
         in_frame_reg <= 1'b1;
      end
   end

   // bit count saturates so a long frame never aliases a short one
   always_ff @(posedge link.sclk) begin
      if (!in_frame_reg) begin
         bit_cnt_reg <= CNT_W'(1);
      end else if (bit_cnt_reg != '1) begin
         bit_cnt_reg <= bit_cnt_reg + CNT_W'(1);
      end
   end

   // input shifter and field capture
   always_ff @(posedge link.sclk) begin
      shin_reg <= {shin_reg[30:0], link.serial_in_line};
      if (!in_frame_reg) begin
         cmd_reg <= 8'h00;
      end else if (bit_cnt_reg == CNT_W'(LEN_CMD - 1)) begin
         cmd_reg <= byte_in;
      end
      if (in_frame_reg && bit_cnt_reg == CNT_W'(LEN_STATUS_WRITE_CMD - 1)) begin
         data_reg <= byte_in; // [RULE_06]
      end
      if (in_frame_reg && bit_cnt_reg == CNT_W'(LEN_ERASE - 1)) begin
         addr_reg <= {shin_reg[22:0], link.serial_in_line};
      end
   end

   // status byte brought onto the link clock; fresh after the command byte
   swp_sync #(
      .W (8)
   ) u_stat_sync (
      .clk_i (link.sclk),
      .d_i   (stat_view),
      .q_o   (stat_l)
   );

   // status read works whatever the busy state
   assign rd_now = in_frame_reg && (cmd_reg == CMD_STATUS_READ) &&
                   (bit_cnt_reg >= CNT_W'(LEN_CMD)); // [RULE_01]

   // output shifter on the falling edge, reloaded every byte until the bit count saturates
   always_ff @(negedge link.sclk or posedge link.sel_n) begin
      if (link.sel_n) begin
         link.serial_out_oe   <= 1'b0;
         link.serial_out_line <= 1'b1;
         shout_reg            <= 7'h00;
      end else begin
         link.serial_out_oe <= rd_now;
         if (rd_now && bit_cnt_reg[2:0] == 3'h0) begin
            link.serial_out_line <= stat_l[7]; // [RULE_03]
            shout_reg            <= stat_l[6:0];
         end else begin
            link.serial_out_line <= shout_reg[6];
            shout_reg            <= {shout_reg[5:0], 1'b0};
         end
      end
   end

   // select and protect pin into the system domain
   swp_sync #(
      .W (2)
   ) u_pin_sync (
      .clk_i (clk_sys_i),
      .d_i   ({link.sel_n, link.wp_n}),
      .q_o   ({sel_s, wp_s})
   );

   // select rise marks the end of a frame; link fields are still then
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         sel_d_reg <= 1'b1;
      end else begin
         sel_d_reg <= sel_s;
      end
   end

   assign frame_end = sel_s & ~sel_d_reg;

   // frame decode and acceptance
   always_comb begin
      hpm_now  = lock_reg & ~wp_s; // [RULE_19] [RULE_22]
      is_write_latch_set_cmd  = (cmd_reg == CMD_WRITE_LATCH) && (bit_cnt_reg == CNT_W'(LEN_CMD));
      is_status_write_cmd  = (cmd_reg == CMD_STATUS_WRITE) && (bit_cnt_reg == CNT_W'(LEN_STATUS_WRITE_CMD)); // [RULE_08]
      is_prog  = is_program(cmd_reg) && (bit_cnt_reg >= CNT_W'(LEN_PROG)) &&
                 (bit_cnt_reg[2:0] == 3'h0) && (bit_cnt_reg != '1);
      is_erase = ((cmd_reg == CMD_SUBSECT_ERASE) || (cmd_reg == CMD_SECTOR_ERASE)) &&
                 (bit_cnt_reg == CNT_W'(LEN_ERASE));
      is_bulk  = (cmd_reg == CMD_BULK_ERASE) && (bit_cnt_reg == CNT_W'(LEN_CMD));
      // latch needed; lock with low pin refuses regardless
      go_status_write_cmd  = frame_end & is_status_write_cmd & wel_reg & ~busy_reg & ~hpm_now; // [RULE_04] [RULE_15] [RULE_16] [RULE_17] [RULE_18]
      go_mod   = frame_end & wel_reg & ~busy_reg &
                 (((is_prog | is_erase) & ~guard_hit(addr_reg, bp_reg, tb_reg)) |
                  (is_bulk & (bp_reg == 4'h0))); // [RULE_21]
      cyc_done = busy_reg && (cyc_reg == '0);
   end

   // self-timed cycle: busy and ready flags move together
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         busy_reg      <= 1'b0;
         rdy_reg       <= 1'b1;
         kind_status_write_cmd_reg <= 1'b0;
         cyc_reg       <= '0;
         new_reg       <= 8'h00;
      end else if (go_status_write_cmd) begin
         busy_reg      <= 1'b1; // [RULE_09] [RULE_10] [RULE_23]
         rdy_reg       <= 1'b0;
         kind_status_write_cmd_reg <= 1'b1;
         cyc_reg       <= CYC_W'(STATUS_WRITE_CMD_CYC - 1);
         new_reg       <= data_reg;
      end else if (go_mod) begin
         busy_reg      <= 1'b1; // [RULE_23]
         rdy_reg       <= 1'b0;
         kind_status_write_cmd_reg <= 1'b0;
         cyc_reg       <= CYC_W'(PROG_CYC - 1);
      end else if (cyc_done) begin
         busy_reg <= 1'b0; // [RULE_10]
         rdy_reg  <= 1'b1;
      end else if (busy_reg) begin
         cyc_reg <= cyc_reg - CYC_W'(1);
      end
   end

   // guard bits change only at the end of an accepted status write
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         lock_reg <= RST_LOCK; // [RULE_14]
         tb_reg   <= RST_TB;
         bp_reg   <= RST_BP;
      end else if (cyc_done && kind_status_write_cmd_reg) begin
         lock_reg <= new_reg[BIT_LOCK]; // [RULE_13]
         tb_reg   <= new_reg[BIT_TB];
         bp_reg   <= {new_reg[BIT_BP3], new_reg[BIT_BP_LO+2:BIT_BP_LO]}; // [RULE_12] [RULE_07]
      end
   end

   // write enable latch; a write enable while busy is ignored
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         wel_reg <= 1'b0;
      end else if (frame_end && is_write_latch_set_cmd && !busy_reg) begin
         wel_reg <= 1'b1; // [RULE_05]
      end else if (cyc_done) begin
         wel_reg <= 1'b0; // [RULE_11]
      end
   end

   // guard mode and refusal report; guard follows the pin, no command exits
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         hpm_reg     <= 1'b0;
         refused_reg <= 1'b0;
      end else begin
         hpm_reg     <= hpm_now; // [RULE_20]
         refused_reg <= frame_end & is_status_write_cmd & ~go_status_write_cmd;
      end
   end

   // busy in bit zero, latch in bit one
   assign stat_view = {lock_reg, bp_reg[3], tb_reg, bp_reg[2:0],
                       wel_reg, busy_reg}; // [RULE_24]

   assign status_o        = stat_view;
   assign hw_guard_o      = hpm_reg;
   assign ctrl_ready_o    = rdy_reg;
   assign write_refused_o = refused_reg;
endmodule

/* swp_host.sv */
/*
 swp_host: host controller end; makes the link clock by a divider, polls
 busy before every command except status read and precedes latch-needing commands by write enable.
 Assumes one request at a time on a valid/ready handshake.
*/
`timescale 1ns/100ps
module swp_host #(
   parameter int unsigned HALF = swp_pkg::SCLK_HALF_CYC,
   parameter int unsigned GAP  = swp_pkg::CS_GAP_CYC
) (
   // system side
   input  wire logic        clk_sys_i,
   input  wire logic        srst_i,
   // request
   input  wire logic        req_valid_i,
   input  wire logic [7:0]  req_cmd_i,
   input  wire logic [23:0] req_addr_i,
   input  wire logic [7:0]  req_data_i,
   input  wire logic [2:0]  req_len_i,
   input  wire logic        wp_level_i,
   // answer
   output logic             req_ready_o,
   output logic             done_o,
   output logic [7:0]       rdata_o,
   // serial link, host end
   swp_link_if.host         link
);
   import swp_pkg::*;

   swp_hstate_t state_reg;
   swp_hstate_t next_reg;
   logic [7:0]  div_reg;
   logic [7:0]  gap_reg;
   logic [39:0] tx_reg;
   logic [5:0]  nbits_reg;
   logic [5:0]  rise_reg;
   logic [7:0]  rx_reg;
   logic [7:0]  cmd_reg;
   logic [23:0] addr_reg;
   logic [7:0]  data_reg;
   logic [2:0]  len_reg;
   logic        miso_s;
   logic [7:0]  rx_next;
   logic [5:0]  rise_nx;
   logic        fall_end;
   logic [39:0] fr_tx;
   logic [5:0]  fr_bits;

   // device output is launched on a foreign edge
   swp_sync #(
      .W (1)
   ) u_miso_sync (
      .clk_i (clk_sys_i),
      .d_i   (link.serial_out_wire),
      .q_o   (miso_s)
   );

   // frame contents and end test
   always_comb begin
      rx_next = {rx_reg[6:0], miso_s};
      rise_nx = rise_reg + 6'd1;
      if (state_reg == H_POLL && rise_reg == 6'd23) begin
         rise_nx = 6'd16; // keep counting bytes while polling
      end
      if (state_reg == H_POLL) begin
         fall_end = (rise_reg[2:0] == 3'h0) && (rise_reg >= 6'd16) &&
                    !rx_next[BIT_BUSY]; // [RULE_02]
      end else begin
         fall_end = (rise_reg == nbits_reg); // [RULE_08]
      end
      case (next_reg)
         H_POLL: begin
            fr_tx   = {CMD_STATUS_READ, 32'h0};
            fr_bits = 6'(LEN_STATUS_WRITE_CMD);
         end
         H_WRITE_LATCH_SET_CMD: begin
            fr_tx   = {CMD_WRITE_LATCH, 32'h0};
            fr_bits = 6'(LEN_CMD);
         end
         default: begin
            fr_tx   = (len_reg == 3'h2) ? {cmd_reg, data_reg, 24'h0}
                                        : {cmd_reg, addr_reg, data_reg}; // [RULE_06]
            fr_bits = {len_reg, 3'h0};
         end
      endcase
   end

   // sequencer and bit engine; data changes while the clock is low
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         state_reg   <= H_IDLE;
         next_reg    <= H_IDLE;
         div_reg     <= 8'h00;
         gap_reg     <= 8'h00;
         tx_reg      <= 40'h0;
         nbits_reg   <= 6'h00;
         rise_reg    <= 6'h00;
         rx_reg      <= 8'h00;
         cmd_reg     <= 8'h00;
         addr_reg    <= 24'h0;
         data_reg    <= 8'h00;
         len_reg     <= 3'h0;
         link.sclk   <= 1'b0;
         link.sel_n  <= 1'b1;
         link.serial_in_line <= 1'b0;
         req_ready_o <= 1'b1;
         done_o      <= 1'b0;
         rdata_o     <= 8'h00;
      end else begin
         done_o <= 1'b0;
         case (state_reg)
            H_IDLE: begin
               if (req_valid_i && req_ready_o) begin
                  req_ready_o <= 1'b0;
                  cmd_reg     <= req_cmd_i;
                  addr_reg    <= req_addr_i;
                  data_reg    <= req_data_i;
                  len_reg     <= req_len_i;
                  gap_reg     <= 8'h00;
                  next_reg    <= (req_cmd_i == CMD_STATUS_READ) ? H_SEND : H_POLL;
                  state_reg   <= H_GAP;
               end
            end
            H_GAP: begin
               if (gap_reg == 8'(GAP - 1)) begin
                  gap_reg <= 8'h00;
                  if (next_reg == H_IDLE) begin
                     state_reg   <= H_IDLE;
                     done_o      <= 1'b1;
                     req_ready_o <= 1'b1;
                  end else begin
                     state_reg  <= next_reg;
                     link.sel_n <= 1'b0;
                     link.serial_in_line <= fr_tx[39];
                     tx_reg     <= {fr_tx[38:0], 1'b0};
                     nbits_reg  <= fr_bits;
                     rise_reg   <= 6'h00;
                     div_reg    <= 8'h00;
                  end
               end else begin
                  gap_reg <= gap_reg + 8'h01;
               end
            end
            H_POLL, H_WRITE_LATCH_SET_CMD, H_SEND: begin
               if (div_reg == 8'(HALF - 1)) begin
                  div_reg <= 8'h00;
                  if (!link.sclk) begin
                     link.sclk <= 1'b1;
                     rise_reg  <= rise_nx;
                  end else begin
                     link.sclk <= 1'b0;
                     rx_reg    <= rx_next;
                     if (fall_end) begin
                        link.sel_n <= 1'b1; // [RULE_08]
                        state_reg  <= H_GAP;
                        gap_reg    <= 8'h00;
                        if (state_reg == H_SEND) begin
                           next_reg <= H_IDLE;
                           rdata_o  <= rx_next;
                        end else if (state_reg == H_POLL && needs_wel(cmd_reg)) begin
                           next_reg <= H_WRITE_LATCH_SET_CMD; // [RULE_04]
                        end else begin
                           next_reg <= H_SEND;
                        end
                     end else begin
                        link.serial_in_line <= tx_reg[39];
                        tx_reg <= {tx_reg[38:0], 1'b0};
                     end
                  end
               end else begin
                  div_reg <= div_reg + 8'h01;
               end
            end
            default: begin
               state_reg <= H_IDLE;
            end
         endcase
      end
   end

   // protect pin follows the user level
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         link.wp_n <= 1'b1;
      end else begin
         link.wp_n <= wp_level_i;
      end
   end
endmodule

/* swp_link_if.sv */
/*
 swp_link_if: serial link between host controller and flash device.
 Assumes the host makes the clock, select and protect pin.
*/
`timescale 1ns/100ps
interface swp_link_if;
   logic sclk;
   logic sel_n;
   logic serial_in_line;
   logic serial_out_line;
   logic serial_out_oe;
   logic wp_n;
   logic serial_out_wire;

   // line floats high when the device lets go
   assign serial_out_wire = serial_out_oe ? serial_out_line : 1'b1;

   modport dev (input sclk, sel_n, serial_in_line, wp_n, output serial_out_line, serial_out_oe);
   modport host (output sclk, sel_n, serial_in_line, wp_n, input serial_out_wire);
endinterface

/* swp_link_sva.sv */
/* swp_link_sva: wire checks on the serial link between both ends.
 Assumes the host clock is sampled on clk_sys_i. */
`timescale 1ns/100ps
module swp_link_sva (
   // system clock and reset
   input wire logic clk_sys_i,
   input wire logic srst_i,
   // link wires
   input wire logic sclk,
   input wire logic sel_n,
   input wire logic serial_in_line,
   input wire logic serial_out_line,
   input wire logic serial_out_oe
);
   logic [11:0] rise_cnt;
   logic        sclk_q;
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (srst_i);
   // rising clock edges within one frame
   always_ff @(posedge clk_sys_i) begin
      sclk_q <= sclk;
      if (sel_n) begin
         rise_cnt <= 12'h000;
      end else if (sclk && !sclk_q) begin
         rise_cnt <= rise_cnt + 12'h001;
      end
   end
   // one divider high phase
   sequence s_high_phase;
      sclk [*4] ##1 !sclk;
   endsequence
   // output bit moved inside a frame
   sequence s_out_moved;
      !sel_n && !$past(sel_n) && $changed(serial_out_line);
   endsequence
   a_sclk_idle_low: assert property (sel_n |-> !sclk)
      else $error("link clock runs outside a frame");
   a_high_phase: assert property ($rose(sclk) |-> s_high_phase)
      else $error("link clock high phase wrong");
   a_din_stable: assert property (sclk && $past(sclk) |-> $stable(serial_in_line))
      else $error("input data moved while clock high");
   a_sel_on_byte: assert property ($rose(sel_n) |-> rise_cnt[2:0] == 3'h0)
      else $error("select rose off a byte boundary");
   a_out_release: assert property (sel_n |-> !serial_out_oe)
      else $error("device drives while deselected");
   a_out_after_cmd: assert property ($rose(serial_out_oe) |-> rise_cnt == 12'h008)
      else $error("status output not after command byte");
   // select rising releases the line in the same cycle, so that is allowed
   a_oe_held: assert property (serial_out_oe && !sel_n |=> serial_out_oe || sel_n)
      else $error("status output stopped while selected");
   a_out_on_fall: assert property (s_out_moved |-> !sclk)
      else $error("output changed off falling edge");
endmodule

/* swp_pkg.sv */
/*
 swp_pkg: shared constants for the status register write-protect link.
 Assumes a single-bit serial link, mode 0, most significant bit first.
*/
package swp_pkg;
   // command codes
   localparam logic [7:0] CMD_STATUS_READ    = 8'h05;
   localparam logic [7:0] CMD_STATUS_WRITE   = 8'h01;
   localparam logic [7:0] CMD_WRITE_LATCH    = 8'h06;
   localparam logic [7:0] CMD_PAGE_PROGRAM   = 8'h02;
   localparam logic [7:0] CMD_DUAL_IN_PROG   = 8'hA2;
   localparam logic [7:0] CMD_DUAL_EXT_PROG  = 8'hD2;
   localparam logic [7:0] CMD_QUAD_IN_PROG   = 8'h32;
   localparam logic [7:0] CMD_QUAD_EXT_PROG  = 8'h12;
   localparam logic [7:0] CMD_SUBSECT_ERASE  = 8'h20;
   localparam logic [7:0] CMD_SECTOR_ERASE   = 8'hD8;
   localparam logic [7:0] CMD_BULK_ERASE     = 8'hC7;
   // status bit positions
   localparam int BIT_BUSY  = 0;
   localparam int BIT_WEL   = 1;
   localparam int BIT_BP_LO = 2;
   localparam int BIT_TB    = 5;
   localparam int BIT_BP3   = 6;
   localparam int BIT_LOCK  = 7;
   // reset values of the guard bits
   localparam logic       RST_LOCK = 1'b0;
   localparam logic       RST_TB   = 1'b0;
   localparam logic [3:0] RST_BP   = 4'h0;
   // frame lengths in bits and the bit counter width
   localparam int LEN_CMD   = 8;
   localparam int LEN_STATUS_WRITE_CMD  = 16;
   localparam int LEN_ERASE = 32;
   localparam int LEN_PROG  = 40;
   localparam int LINK_CNT_W = 12;
   // address map: 64 KiB sectors above bit 16
   localparam logic [8:0] SECT_TOTAL = 9'h100;
   // timing
   localparam int CLK_SYS_NS       = 10;
   localparam int T_STATUS_WR_NS   = 1000000;
   localparam int T_PROGRAM_NS     = 500000;
   localparam int CYC_STATUS_WRITE = T_STATUS_WR_NS / CLK_SYS_NS;
   localparam int CYC_PROGRAM      = T_PROGRAM_NS / CLK_SYS_NS;
   localparam int CYC_W            = 24;
   localparam int SCLK_HALF_CYC    = 4;
   localparam int CS_GAP_CYC       = 8;

   typedef enum logic [2:0] {
      H_IDLE = 3'b000,
      H_POLL = 3'b001,
      H_WRITE_LATCH_SET_CMD = 3'b010,
      H_SEND = 3'b011,
      H_GAP  = 3'b100
   } swp_hstate_t;

   // program variants of any width
   function automatic logic is_program(input logic [7:0] c);
      is_program = (c == CMD_PAGE_PROGRAM) || (c == CMD_DUAL_IN_PROG) ||
                   (c == CMD_DUAL_EXT_PROG) || (c == CMD_QUAD_IN_PROG) ||
                   (c == CMD_QUAD_EXT_PROG);
   endfunction

   // commands that need the write enable latch
   function automatic logic needs_wel(input logic [7:0] c);
      needs_wel = is_program(c) || (c == CMD_STATUS_WRITE) || (c == CMD_BULK_ERASE) ||
                  (c == CMD_SUBSECT_ERASE) || (c == CMD_SECTOR_ERASE);
   endfunction

   // true when the address falls in the guarded area
   function automatic logic guard_hit(input logic [23:0] a, input logic [3:0] bp,
                                      input logic tb);
      logic [8:0] n;
      n = 9'h000;
      if (bp >= 4'h9) begin
         n = SECT_TOTAL;
      end else if (bp != 4'h0) begin
         n = 9'h001 << (bp - 4'h1);
      end
      guard_hit = tb ? ({1'b0, a[23:16]} < n) : ({1'b0, a[23:16]} >= SECT_TOTAL - n);
   endfunction
endpackage

/* swp_sync.sv */
/*
 swp_sync: two-flop level synchroniser, W bits wide.
 Assumes each bit is a level that stays put for several destination edges.
*/
`timescale 1ns/100ps
module swp_sync #(
   parameter int unsigned W = 1
) (
   // destination clock
   input  wire logic         clk_i,
   // asynchronous level in, synchronised level out
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta_reg;

   // first flop feeds only the second
   always_ff @(posedge clk_i) begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
   end
endmodule

/* testbench.sv */
/* testbench: host and device ends joined by the link interface.
 Assumes short write cycles set by parameters to keep the run brief. */
`timescale 1ns/100ps
module testbench;
   import swp_pkg::*;
   localparam int WR_CYC = 400;
   logic        clk_sys_i, srst_i, req_valid_i, wp_level_i, req_ready_o, done_o;
   logic        hw_guard_o, ctrl_ready_o, write_refused_o;
   logic [7:0]  req_cmd_i, req_data_i, rdata_o, status_o, g, d;
   logic [23:0] req_addr_i;
   logic [2:0]  req_len_i;
   logic [8:0]  exp_q[$];
   logic [8:0]  note;
   int          errors, cmp_count, refusals;
   swp_link_if link ();
   swp_host swp_host_inst (.clk_sys_i, .srst_i, .req_valid_i, .req_cmd_i, .req_addr_i,
      .req_data_i, .req_len_i, .wp_level_i, .req_ready_o, .done_o, .rdata_o, .link);
   swp_dev #(.STATUS_WRITE_CMD_CYC(WR_CYC), .PROG_CYC(10)) swp_dev_inst (.clk_sys_i, .srst_i, .link,
      .status_o, .hw_guard_o, .ctrl_ready_o, .write_refused_o);
   swp_link_sva swp_link_sva_inst (.clk_sys_i, .srst_i, .sclk(link.sclk),
      .sel_n(link.sel_n), .serial_in_line(link.serial_in_line),
      .serial_out_line(link.serial_out_line), .serial_out_oe(link.serial_out_oe));
   // free-running system clock
   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run();
      if (errors == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // one host request; hold valid until taken, then wait for done
   task automatic req(input logic [7:0] c, input logic [23:0] a, input logic [7:0] dat,
                      input logic [2:0] len, input logic [8:0] exp);
      exp_q.push_back(exp);
      req_cmd_i   <= c;
      req_addr_i  <= a;
      req_data_i  <= dat;
      req_len_i   <= len;
      req_valid_i <= 1'b1;
      do @(posedge clk_sys_i); while (req_ready_o !== 1'b1);
      req_valid_i <= 1'b0;
      do @(posedge clk_sys_i); while (done_o !== 1'b1);
   endtask
   task automatic rd(input logic [7:0] exp);
      req(CMD_STATUS_READ, 24'h000000, 8'h00, 3'd2, {1'b1, exp});
   endtask
   task automatic wr(input logic [7:0] dat);
      req(CMD_STATUS_WRITE, 24'h000000, dat, 3'd2, 9'h000);
   endtask
   task automatic idle();
      repeat (WR_CYC + 20) @(posedge clk_sys_i);
   endtask
   // guard flag is synchronised, so give it a few cycles
   task automatic guard(input logic e);
      repeat (8) @(posedge clk_sys_i);
      check({7'h00, hw_guard_o}, {7'h00, e}, "hw guard");
   endtask
   // result side: one note taken per completed request
   always @(posedge clk_sys_i) begin
      if (write_refused_o === 1'b1) begin
         refusals++;
      end
      if (done_o === 1'b1) begin
         note = exp_q.pop_front();
         if (note[8]) begin
            check(rdata_o, note[7:0], "status byte");
         end
      end
   end
   // hang guard, well beyond the expected run
   initial begin
      #800000;
      errors++;
      complete_run();
   end
   initial begin
      errors = 0;
      cmp_count = 0;
      refusals = 0;
      srst_i = 1'b1;
      req_valid_i = 1'b0;
      req_cmd_i = 8'h00;
      req_addr_i = 24'h000000;
      req_data_i = 8'h00;
      req_len_i = 3'h0;
      wp_level_i = 1'b1;
      void'($urandom(32'hE6FD));
      repeat (2) @(posedge clk_sys_i);
      srst_i <= 1'b0;
      rd(8'h00);
      req(CMD_WRITE_LATCH, 24'h000000, 8'h00, 3'd1, 9'h000);
      rd(8'h02);
      // pin low first, then lock set by an accepted write
      wp_level_i <= 1'b0;
      d = 8'($urandom) | 8'h80;
      wr(d);
      rd(8'h03);
      idle();
      g = d & 8'hFC;
      rd(g);
      guard(1'b1);
      wr(8'($urandom));
      rd(g | 8'h02);
      wp_level_i <= 1'b1;
      guard(1'b0);
      d = 8'($urandom) | 8'h80;
      wr(d);
      rd(g | 8'h03);
      idle();
      g = d & 8'hFC;
      rd(g);
      // lock already set, then pin low
      wp_level_i <= 1'b0;
      guard(1'b1);
      wp_level_i <= 1'b1;
      guard(1'b0);
      wr(8'h24);
      // second write issued while busy: host must poll before it
      wr(8'h24);
      check(status_o, 8'h27, "status view");
      check({7'h00, ctrl_ready_o}, 8'h00, "ctrl ready busy");
      idle();
      check({7'h00, ctrl_ready_o}, 8'h01, "ctrl ready done");
      check(status_o, 8'h24, "status view");
      rd(8'h24);
      // one byte short: discarded, latch kept
      req(CMD_STATUS_WRITE, 24'h000000, 8'h00, 3'd1, 9'h000);
      rd(8'h26);
      req(CMD_SECTOR_ERASE, 24'h000000, 8'h00, 3'd4, 9'h000);
      rd(8'h26);
      req(CMD_SECTOR_ERASE, 24'h100000, 8'h00, 3'd4, 9'h000);
      rd(8'h24);
      req(CMD_BULK_ERASE, 24'h000000, 8'h00, 3'd1, 9'h000);
      rd(8'h26);
      check(8'(refusals), 8'h01, "refusal pulses");
      complete_run();
   end
endmodule
